//--- wpm_pkg.sv
package wpm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PMC    = 8'h04;
    localparam logic [7:0] OFS_PMCSR  = 8'h08;
    localparam logic [7:0] OFS_OPTION = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_CRC0   = 8'h20;

    // Option register bit positions
    localparam int OPT_WAKE_SIG_EN   = 0;
    localparam int OPT_LINK_WAKE_EN  = 4;
    localparam int OPT_PATTERN_EN    = 5;
    localparam int OPT_LEGACY_GATING = 8;
    localparam int OPT_DIRECT_WAKE   = 9;
    localparam int OPT_LEGACY_EN     = 10;
    localparam int OPT_FRAME_EN_LSB  = 16;

    // Power management control/status fields
    localparam int PMCSR_STATE_LSB = 0;
    localparam int PMCSR_PME_EN    = 8;
    localparam int PMCSR_PME_STAT  = 15;

    // Capability fields cleared without auxiliary power
    localparam logic [15:0] PMC_AUX_MASK  = 16'h81c0;
    localparam int          PMC_SUPP_LSB  = 11;
    localparam logic [15:0] PMC_RESET     = 16'h0000;
    localparam logic [31:0] OPTION_RESET  = 32'h0000_0000;

    localparam int NUM_FRAMES   = 5;
    localparam int NUM_SHORT    = 2;
    localparam int SHORT_LEN    = 64;
    localparam int LONG_LEN     = 128;
    localparam int SYNC_BYTES   = 6;
    localparam int ADDR_REPEATS = 16;
    localparam logic [15:0] CRC16_POLY = 16'h8005;

    typedef enum logic [1:0] {
        WPM_D0,
        WPM_D1,
        WPM_D2,
        WPM_D3
    } wpm_pstate_type;

    typedef enum {
        WPM_HUNT,
        WPM_SYNC,
        WPM_ADDR,
        WPM_FOUND
    } wpm_pat_type;

    // One received byte from the network receive path
    typedef struct packed {
        logic       valid;
        logic       first;
        logic       last;
        logic [7:0] data;
    } wpm_rxbyte_type;

    // End-of-frame verdict of the receive path
    typedef struct packed {
        logic addr_ok;
        logic crc_ok;
    } wpm_rxinfo_type;

endpackage

//--- wpm_top.sv
// Overview of operation
// RL1: Low power halts receive machine yet keeps watching for wake events.
// RL2: Low power: no packet status into interrupt status, no FIFO writes.
// RL3: Receive FIFO contents and status are held untouched in low power.
// RL4: Low power stops transmit and bus mastering, transmit FIFO kept.
// RL5: Back in D0, DMA resumes where stopped, unfinished packet resent whole.
// RL6: Capability bit15 and bits 8:6 zeroed without aux power, else copied.
// RL7: Link wake needs link wake enable, signal enable, allowed state, relink.
// RL8: Pattern wake needs good address, good CRC, enables, allowed state.
// RL9: Pattern is six 0xff bytes then sixteen station address copies.
// RL10: Wake frame needs address, CRC, signal enable and CRC or direct wake.
// RL11: Five wake frames: two over bytes 0..63, three over 0..127.
// RL12: Event output needs both enables, allowed state or isolation, event.
// RL13: Writing one to event status clears it and drops the event output.
// RL14: In D1..D3 I/O, memory and boot ROM decode are disabled.
// RL15: Bus reset returns power state to D0.
// RL16: Power state writes take effect at once.
// RL17: Legacy wake gated by event output and isolation when gating set.
// RL18: EEPROM option bit enables or disables legacy wake entirely.
// RL19: Default capability gives no event support from D0.
// RL20: Wake event sets sticky status held until software clears it.
`timescale 1ns/1ps
module wpm_top (
    input  wire logic                   CLK,
    input  wire logic                   RST_N,
    input  wire logic                   HSEL,
    input  wire logic [31:0]            HADDR,
    input  wire logic [1:0]             HTRANS,
    input  wire logic                   HWRITE,
    input  wire logic [2:0]             HSIZE,
    input  wire logic [31:0]            HWDATA,
    input  wire logic                   HREADY,
    output logic      [31:0]            HRDATA,
    output logic                        HREADYOUT,
    output logic                        HRESP,
    input  wire logic [15:0]            EE_PMC,
    input  wire logic                   EE_LEGACY_EN,
    input  wire logic                   AUX_POWER,
    input  wire logic [47:0]            STATION_ADDR,
    input  wire logic                   ISOLATION_N,
    input  wire logic                   LINK_UP,
    input  wire wpm_pkg::wpm_rxbyte_type RX_BYTE,
    input  wire wpm_pkg::wpm_rxinfo_type RX_INFO,
    input  wire logic                   RX_END,
    input  wire logic                   TX_BUSY,
    output logic                        RX_HALT,
    output logic                        RX_STATUS_EN,
    output logic                        RX_FIFO_WR_EN,
    output logic                        TX_HALT,
    output logic                        DMA_HALT,
    output logic                        TX_RESTART,
    output logic                        IO_DECODE_EN,
    output logic                        MEM_DECODE_EN,
    output logic                        ROM_DECODE_EN,
    output logic                        POWER_EVENT_OUT_N,
    output logic                        LEGACY_WAKE_OUT
);

    logic                   rst_meta;
    logic                   rst_sync_n;
    logic                   ph_valid;
    logic                   ph_write;
    logic [7:0]             ph_addr;
    logic [31:0]            option_reg;
    logic [15:0]            pmc;
    wpm_pkg::wpm_pstate_type pstate;
    logic                   pme_en;
    logic                   pme_status;
    logic [15:0]            frame_crc [wpm_pkg::NUM_FRAMES];
    logic                   link_q;
    logic                   tx_cut;
    logic [15:0]            run_crc;
    logic [7:0]             byte_cnt;
    wpm_pkg::wpm_pat_type   pat_st;
    logic [2:0]             sync_cnt;
    logic [6:0]             addr_cnt;
    logic                   pat_seen;
    logic [15:0]            crc_short;
    logic [15:0]            crc_long;
    logic [7:0]             last_data;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Power state decode
    wire low_power  = (pstate != wpm_pkg::WPM_D0);
    wire wake_sig   = option_reg[wpm_pkg::OPT_WAKE_SIG_EN];
    // Support bit index 11+state; D3 uses the hot bit here
    wire [4:0] supp = pmc[15:wpm_pkg::PMC_SUPP_LSB];
    wire state_ok   = supp[pstate];                                            // RL19
    wire signal_ok  = state_ok || !ISOLATION_N;

    assign RX_HALT       = low_power;                                          // RL1
    assign RX_STATUS_EN  = !low_power;                                         // RL2
    assign RX_FIFO_WR_EN = !low_power;                                         // RL2 RL3
    assign TX_HALT       = low_power;                                          // RL4
    assign DMA_HALT      = low_power;                                          // RL4 RL5
    assign IO_DECODE_EN  = !low_power;                                         // RL14
    assign MEM_DECODE_EN = !low_power;                                         // RL14
    assign ROM_DECODE_EN = !low_power;                                         // RL14

    // AHB-Lite slave, zero wait states
    wire take = HSEL && HREADY && HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    wire wr          = ph_valid && ph_write;
    wire wr_ctrl     = wr && (ph_addr == wpm_pkg::OFS_CTRL);
    wire wr_pmcsr    = wr && (ph_addr == wpm_pkg::OFS_PMCSR);
    wire wr_option   = wr && (ph_addr == wpm_pkg::OFS_OPTION);
    wire [15:0] pmcsr_rd = {pme_status, 6'h00, pme_en, 6'h00, pstate};

    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= 8'h00;
        end else begin
            ph_valid <= take;
            ph_write <= HWRITE;
            ph_addr  <= HADDR[7:0];
        end
    end

    wire [31:0] rd_word =
        (HADDR[7:0] == wpm_pkg::OFS_PMC)    ? {16'h0000, pmc} :
        (HADDR[7:0] == wpm_pkg::OFS_PMCSR)  ? {16'h0000, pmcsr_rd} :
        (HADDR[7:0] == wpm_pkg::OFS_OPTION) ? option_reg :
        (HADDR[7:0] == wpm_pkg::OFS_STATUS) ? {28'h0000000, LINK_UP, pat_seen,
                                                low_power, pme_status} :
        (HADDR[7:0] >= wpm_pkg::OFS_CRC0 && HADDR[7:0] < 8'h34)
            ? {16'h0000, frame_crc[3'(HADDR[4:2])]} : 32'h0000_0000;

    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n)
            HRDATA <= 32'h0000_0000;
        else if (take && !HWRITE)
            HRDATA <= rd_word;
    end

    // Capability reloaded from EE_PMC every cycle after reset release; aux power gates the D3cold fields
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n)
            pmc <= wpm_pkg::PMC_RESET;
        else
            pmc <= AUX_POWER ? EE_PMC : (EE_PMC & ~wpm_pkg::PMC_AUX_MASK);  // RL6
    end

    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n)
            option_reg <= wpm_pkg::OPTION_RESET;
        else if (wr_option)
            option_reg <= HWDATA;
    end

    // Reset returns D0; writes change state the same cycle
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pstate <= wpm_pkg::WPM_D0;                                         // RL15
            pme_en <= 1'b0;
        end else if (wr_pmcsr) begin
            pstate <= wpm_pkg::wpm_pstate_type'(HWDATA[1:0]);                  // RL16
            pme_en <= HWDATA[wpm_pkg::PMCSR_PME_EN];
        end
    end

    generate
        for (genvar i = 0; i < wpm_pkg::NUM_FRAMES; i++) begin : g_crc
            always_ff @(posedge CLK or negedge rst_sync_n) begin
                if (!rst_sync_n)
                    frame_crc[i] <= 16'h0000;
                else if (wr && ph_addr == 8'(wpm_pkg::OFS_CRC0 + 4 * i))
                    frame_crc[i] <= HWDATA[15:0];
            end
        end
    endgenerate

    // Transmit restart: a packet cut by low power is resent from its start
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_cut     <= 1'b0;
            TX_RESTART <= 1'b0;
        end else begin
            TX_RESTART <= tx_cut && !low_power;                                // RL5
            if (low_power && TX_BUSY)
                tx_cut <= 1'b1;
            else if (!low_power)
                tx_cut <= 1'b0;
        end
    end

    // Link restore edge
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n)
            link_q <= 1'b0;
        else
            link_q <= LINK_UP;
    end
    wire link_restored_event = LINK_UP && !link_q;
    wire link_wake = link_restored_event && wake_sig && signal_ok             // RL7
                     && option_reg[wpm_pkg::OPT_LINK_WAKE_EN];

    // Pattern matcher over the byte stream
    wire [7:0] rx_d   = RX_BYTE.data;
    wire [2:0] a_idx  = 3'(addr_cnt % 7'd6);
    wire [7:0] a_byte = STATION_ADDR[8'(47 - 8 * a_idx) -: 8];

    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pat_st   <= wpm_pkg::WPM_HUNT;
            sync_cnt <= 3'h0;
            addr_cnt <= 7'h00;
        end else if (RX_BYTE.valid) begin
            if (RX_BYTE.first) begin
                pat_st   <= (rx_d == 8'hff) ? wpm_pkg::WPM_SYNC : wpm_pkg::WPM_HUNT;
                sync_cnt <= (rx_d == 8'hff) ? 3'h1 : 3'h0;
                addr_cnt <= 7'h00;
            end else begin
                case (pat_st)
                    wpm_pkg::WPM_HUNT: begin
                        pat_st   <= (rx_d == 8'hff) ? wpm_pkg::WPM_SYNC : wpm_pkg::WPM_HUNT;
                        sync_cnt <= (rx_d == 8'hff) ? 3'h1 : 3'h0;
                    end
                    wpm_pkg::WPM_SYNC: begin                                   // RL9
                        if (rx_d == 8'hff) begin
                            if (sync_cnt != 3'(wpm_pkg::SYNC_BYTES))
                                sync_cnt <= sync_cnt + 3'h1;
                        end else if (sync_cnt == 3'(wpm_pkg::SYNC_BYTES)
                                     && rx_d == STATION_ADDR[47:40]) begin
                            pat_st   <= wpm_pkg::WPM_ADDR;
                            addr_cnt <= 7'h01;
                        end else if (sync_cnt != 3'(wpm_pkg::SYNC_BYTES)) begin
                            pat_st   <= wpm_pkg::WPM_HUNT;
                            sync_cnt <= 3'h0;
                        end
                    end
                    wpm_pkg::WPM_ADDR: begin
                        if (rx_d != a_byte) begin
                            pat_st   <= (rx_d == 8'hff) ? wpm_pkg::WPM_SYNC : wpm_pkg::WPM_HUNT;
                            sync_cnt <= (rx_d == 8'hff) ? 3'h1 : 3'h0;
                        end else if (addr_cnt == 7'(6 * wpm_pkg::ADDR_REPEATS - 1))
                            pat_st <= wpm_pkg::WPM_FOUND;
                        else
                            addr_cnt <= addr_cnt + 7'h01;
                    end
                    default: pat_st <= wpm_pkg::WPM_FOUND;
                endcase
            end
        end
    end

    // Frame CRC over the first bytes; taps at the short and long window ends
    wire [15:0] crc_in = RX_BYTE.first ? 16'hffff : run_crc;
    logic [15:0] next_crc;
    always_comb begin
        next_crc = crc_in;
        for (int b = 0; b < 8; b++) begin
            if (next_crc[15] ^ rx_d[b])
                next_crc = (next_crc << 1) ^ wpm_pkg::CRC16_POLY;
            else
                next_crc = next_crc << 1;
        end
    end

    wire [7:0] cnt_in = RX_BYTE.first ? 8'h00 : byte_cnt;
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            run_crc   <= 16'hffff;
            byte_cnt  <= 8'h00;
            crc_short <= 16'h0000;
            crc_long  <= 16'h0000;
            last_data <= 8'h00;
        end else if (RX_BYTE.valid) begin
            last_data <= rx_d;
            if (cnt_in < 8'(wpm_pkg::LONG_LEN)) begin                          // RL11
                run_crc  <= next_crc;
                byte_cnt <= cnt_in + 8'h01;
            end
            if (cnt_in == 8'(wpm_pkg::SHORT_LEN - 1))
                crc_short <= next_crc;
            if (cnt_in == 8'(wpm_pkg::LONG_LEN - 1))
                crc_long <= next_crc;
        end
    end

    logic [wpm_pkg::NUM_FRAMES-1:0] frame_hit;
    generate
        for (genvar i = 0; i < wpm_pkg::NUM_FRAMES; i++) begin : g_hit
            if (i < wpm_pkg::NUM_SHORT) begin : g_s
                assign frame_hit[i] = option_reg[wpm_pkg::OPT_FRAME_EN_LSB + i]
                                      && crc_short == frame_crc[i];
            end else begin : g_l
                assign frame_hit[i] = option_reg[wpm_pkg::OPT_FRAME_EN_LSB + i]
                                      && crc_long == frame_crc[i];
            end
        end
    endgenerate

    wire frame_good = RX_END && RX_INFO.addr_ok && RX_INFO.crc_ok;
    wire pattern_wake = frame_good && pat_st == wpm_pkg::WPM_FOUND            // RL8
                        && option_reg[wpm_pkg::OPT_PATTERN_EN]
                        && wake_sig && signal_ok;
    wire frame_wake = frame_good && wake_sig                                   // RL10
                      && (|frame_hit || option_reg[wpm_pkg::OPT_DIRECT_WAKE]);
    wire wake_event = link_wake || pattern_wake || frame_wake;

    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n)
            pat_seen <= 1'b0;
        else if (pattern_wake)
            pat_seen <= 1'b1;
        else if (wr_ctrl && HWDATA[0])
            pat_seen <= 1'b0;
    end

    // Sticky status; a new event beats a same-cycle clear
    always_ff @(posedge CLK or negedge rst_sync_n) begin
        if (!rst_sync_n)
            pme_status <= 1'b0;
        else if (wake_event)
            pme_status <= 1'b1;                                                // RL20
        else if (wr_pmcsr && HWDATA[wpm_pkg::PMCSR_PME_STAT])
            pme_status <= 1'b0;                                                // RL13
    end

    wire pme_active = pme_status && pme_en && wake_sig && signal_ok;           // RL12
    assign POWER_EVENT_OUT_N = !pme_active;

    wire legacy_raw = option_reg[wpm_pkg::OPT_LEGACY_GATING]
                      ? (pme_active && !ISOLATION_N)                            // RL17
                      : pme_status;
    assign LEGACY_WAKE_OUT = legacy_raw && EE_LEGACY_EN;                       // RL18

endmodule // wpm_top

//--- wpm_rx_src.sv
`timescale 1ns/1ps
module wpm_rx_src (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               go,
    input  wire logic               crc_ok,
    input  wire logic [47:0]        station,
    output wpm_pkg::wpm_rxbyte_type rx_byte,
    output wpm_pkg::wpm_rxinfo_type rx_info,
    output logic                    rx_end
);
    logic [7:0] idx;
    logic       busy;
    wire  [7:0] sa_off = idx - 8'h08;
    wire  [7:0] sa_byte = station[47 - 8 * (sa_off % 6) -: 8];
    // Two filler bytes ahead of the sync run, then sixteen address copies
    wire  [7:0] pat = (idx < 8'h02) ? 8'h5a : (idx < 8'h08) ? 8'hff : sa_byte;
    assign rx_info = {1'b1, crc_ok};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            idx <= 8'h00;
            rx_byte <= '0;
            rx_end <= 1'b0;
        end else begin
            rx_end <= rx_byte.valid & rx_byte.last;
            if (busy) begin
                rx_byte <= {1'b1, idx == 8'h00, idx == 8'h67, pat};
                idx <= idx + 8'h01;
                busy <= (idx != 8'h67);
            end else begin
                // Idle data keeps toggling so a stale byte never looks valid
                rx_byte <= {3'b000, ~rx_byte.data};
                busy <= go;
                idx <= 8'h00;
            end
        end
    end
endmodule // wpm_rx_src

//--- wpm_asserts.sv
`timescale 1ns/1ps
module wpm_asserts (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        EE_LEGACY_EN,
    input wire logic        LINK_UP,
    input wire logic        RX_END,
    input wire logic        RX_HALT,
    input wire logic        RX_STATUS_EN,
    input wire logic        RX_FIFO_WR_EN,
    input wire logic        TX_HALT,
    input wire logic        DMA_HALT,
    input wire logic        TX_RESTART,
    input wire logic        IO_DECODE_EN,
    input wire logic        MEM_DECODE_EN,
    input wire logic        ROM_DECODE_EN,
    input wire logic        POWER_EVENT_OUT_N,
    input wire logic        LEGACY_WAKE_OUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic        ph_wr;
    logic [31:0] ph_addr;
    wire         pmcsr_wr = ph_wr && (ph_addr[7:0] == wpm_pkg::OFS_PMCSR);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ph_wr <= 1'b0;
            ph_addr <= 32'h0000_0000;
        end else begin
            ph_wr <= HSEL && HREADY && HTRANS[1] && HWRITE;
            ph_addr <= HADDR;
        end
    end
    a_halt_blocks_rx: assert property ((RX_HALT != RX_FIFO_WR_EN) && (RX_HALT != RX_STATUS_EN))
        else $error("receive path active while halted");
    a_halt_tx_dma: assert property ((TX_HALT == RX_HALT) && (DMA_HALT == RX_HALT))
        else $error("transmit or dma halt differs from receive halt");
    a_decode_off: assert property ({IO_DECODE_EN, MEM_DECODE_EN, ROM_DECODE_EN} == {3{!RX_HALT}})
        else $error("address decode wrong for power state");
    a_reset_d0: assert property (disable iff (1'b0)
        !RST_N |-> !RX_HALT && POWER_EVENT_OUT_N && !LEGACY_WAKE_OUT)
        else $error("reset did not return to full power");
    a_state_write: assert property (pmcsr_wr |=> RX_HALT == ($past(HWDATA[1:0]) != 2'b00))
        else $error("power state write not applied at once");
    a_restart_pulse: assert property (TX_RESTART |->
        !RX_HALT && ($past(RX_HALT) || $past(RX_HALT, 2)) ##1 !TX_RESTART)
        else $error("restart pulse outside return to full power");
    a_w1c_clear: assert property (pmcsr_wr && HWDATA[15] && !RX_END && !$rose(LINK_UP)
        |=> POWER_EVENT_OUT_N)
        else $error("event output still asserted after clear");
    a_legacy_off: assert property (!EE_LEGACY_EN && !$past(EE_LEGACY_EN) |-> !LEGACY_WAKE_OUT)
        else $error("legacy wake asserted while disabled");
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus slave not ready or not okay");
endmodule // wpm_asserts
bind wpm_top wpm_asserts u_chk (.CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
    .HREADY, .HREADYOUT, .HRESP, .EE_LEGACY_EN, .LINK_UP, .RX_END, .RX_HALT, .RX_STATUS_EN,
    .RX_FIFO_WR_EN, .TX_HALT, .DMA_HALT, .TX_RESTART, .IO_DECODE_EN, .MEM_DECODE_EN,
    .ROM_DECODE_EN, .POWER_EVENT_OUT_N, .LEGACY_WAKE_OUT);

//--- wake_power_management_tb.sv
`timescale 1ns/1ps
module wake_power_management_tb;
    typedef struct packed {
        logic [1:0]  st;
        logic [15:0] ee;
        logic        aux;
        logic [15:0] pmc;
        logic        halt;
    } wpm_row_type;
    logic CLK, RST_N, HSEL, HWRITE, EE_LEGACY_EN, AUX_POWER, ISOLATION_N, LINK_UP, TX_BUSY;
    logic go, crc_ok, seen;
    logic [31:0] HADDR, HWDATA, rd, opt;
    logic [1:0]  HTRANS;
    logic [15:0] EE_PMC;
    wire  [31:0] HRDATA;
    wire HREADYOUT, HRESP, RX_HALT, RX_STATUS_EN, RX_FIFO_WR_EN, TX_HALT, DMA_HALT, TX_RESTART;
    wire IO_DECODE_EN, MEM_DECODE_EN, ROM_DECODE_EN, POWER_EVENT_OUT_N, LEGACY_WAKE_OUT, RX_END;
    wpm_pkg::wpm_rxbyte_type RX_BYTE;
    wpm_pkg::wpm_rxinfo_type RX_INFO;
    int mismatches;
    int n_tests;
    localparam logic [47:0] STATION = 48'h02a4_5c19_e3d6;
    wpm_row_type rows [4] = '{'{2'd0, 16'hc2f7, 1'b1, 16'hc2f7, 1'b0},
        '{2'd1, 16'hc2f7, 1'b0, 16'h4237, 1'b1}, '{2'd2, 16'hc277, 1'b1, 16'hc277, 1'b1},
        '{2'd3, 16'hffff, 1'b0, 16'h7e3f, 1'b1}};
    wpm_top dut (.CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'b010), .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .EE_PMC, .EE_LEGACY_EN, .AUX_POWER,
        .STATION_ADDR(STATION), .ISOLATION_N, .LINK_UP, .RX_BYTE, .RX_INFO, .RX_END, .TX_BUSY,
        .RX_HALT, .RX_STATUS_EN, .RX_FIFO_WR_EN, .TX_HALT, .DMA_HALT, .TX_RESTART,
        .IO_DECODE_EN, .MEM_DECODE_EN, .ROM_DECODE_EN, .POWER_EVENT_OUT_N, .LEGACY_WAKE_OUT);
    wpm_rx_src u_src (.clk(CLK), .rst_n(RST_N), .go, .crc_ok, .station(STATION),
        .rx_byte(RX_BYTE), .rx_info(RX_INFO), .rx_end(RX_END));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Zero-wait slave, but the master still waits on ready in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h000000, a};
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task automatic frame(input logic ok);
        crc_ok <= ok;
        @(posedge CLK);
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        do @(posedge CLK); while (RX_END !== 1'b1);
        repeat (2) @(posedge CLK);
        #1;
    endtask
    // Reference CRC over the first 64 bytes of the source frame
    function automatic logic [15:0] crc64();
        logic [15:0] c;
        logic [7:0]  b;
        c = 16'hffff;
        for (int k = 0; k < 64; k++) begin
            b = (k < 2) ? 8'h5a : (k < 8) ? 8'hff : STATION[47 - 8 * ((k - 8) % 6) -: 8];
            for (int j = 0; j < 8; j++) c = (c[15] ^ b[j]) ? ((c << 1) ^ 16'h8005) : (c << 1);
        end
        return c;
    endfunction
    task automatic give_verdict();
        if (mismatches == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        give_verdict();
    end
    initial begin
        {HSEL, HWRITE, HTRANS, HADDR, HWDATA, go, crc_ok, LINK_UP, TX_BUSY} = '0;
        {EE_LEGACY_EN, AUX_POWER, ISOLATION_N, EE_PMC} = {3'b111, 16'hc2f7};
        mismatches = 0;
        n_tests = 0;
        RST_N = 1'b0;
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        #1 chk("reset outs", {IO_DECODE_EN, RX_FIFO_WR_EN, POWER_EVENT_OUT_N, LEGACY_WAKE_OUT}, 4'b1110);
        repeat (3) @(posedge CLK);
        foreach (rows[i]) begin
            EE_PMC <= rows[i].ee;
            AUX_POWER <= rows[i].aux;
            bus(1'b1, wpm_pkg::OFS_PMCSR, {30'h0, rows[i].st});
            bus(1'b0, wpm_pkg::OFS_PMC, 32'h0);
            #1 chk("pmc", rd[15:0], rows[i].pmc);
            chk("halts", {RX_HALT, TX_HALT, DMA_HALT}, {3{rows[i].halt}});
            chk("enables", {IO_DECODE_EN, MEM_DECODE_EN, ROM_DECODE_EN, RX_STATUS_EN,
                RX_FIFO_WR_EN}, {5{~rows[i].halt}});
        end
        EE_PMC <= 16'hc2f7;
        AUX_POWER <= 1'b1;
        bus(1'b1, wpm_pkg::OFS_OPTION, 32'h11);
        bus(1'b1, wpm_pkg::OFS_PMCSR, 32'h100);
        LINK_UP <= 1'b1;
        repeat (2) @(posedge CLK);
        #1 chk("d0 event", POWER_EVENT_OUT_N, 1);
        LINK_UP <= 1'b0;
        bus(1'b1, wpm_pkg::OFS_PMCSR, 32'h103);
        LINK_UP <= 1'b1;
        repeat (2) @(posedge CLK);
        #1 chk("d3 event", POWER_EVENT_OUT_N, 0);
        chk("legacy free", LEGACY_WAKE_OUT, 1);
        bus(1'b1, wpm_pkg::OFS_OPTION, 32'h111);
        #1 chk("legacy gated", LEGACY_WAKE_OUT, 0);
        ISOLATION_N <= 1'b0;
        @(posedge CLK);
        #1 chk("legacy isol", {LEGACY_WAKE_OUT, POWER_EVENT_OUT_N}, 2'b10);
        EE_LEGACY_EN <= 1'b0;
        @(posedge CLK);
        #1 chk("legacy off", LEGACY_WAKE_OUT, 0);
        {EE_LEGACY_EN, ISOLATION_N, LINK_UP} <= 3'b110;
        bus(1'b0, wpm_pkg::OFS_STATUS, 32'h0);
        chk("sticky", rd[1:0], 2'b11);
        bus(1'b1, wpm_pkg::OFS_PMCSR, 32'h8103);
        #1 chk("cleared", POWER_EVENT_OUT_N, 1);
        for (int i = 0; i < 2; i++) begin
            opt = (i == 0) ? 32'h21 : 32'h201;
            bus(1'b1, wpm_pkg::OFS_OPTION, opt);
            bus(1'b1, wpm_pkg::OFS_CTRL, 32'h1);
            for (int c = 0; c < 2; c++) begin
                bus(1'b1, wpm_pkg::OFS_PMCSR, 32'h8103);
                frame(c[0]);
                chk("frame event", POWER_EVENT_OUT_N, !c[0]);
            end
            bus(1'b0, wpm_pkg::OFS_STATUS, 32'h0);
            if (i == 0) chk("pattern seen", rd[2], 1);
        end
        bus(1'b1, wpm_pkg::OFS_OPTION, 32'h10001);
        for (int c = 0; c < 2; c++) begin
            bus(1'b1, wpm_pkg::OFS_CRC0, {16'h0000, c[0] ? ~crc64() : crc64()});
            bus(1'b1, wpm_pkg::OFS_PMCSR, 32'h8103);
            frame(1'b1);
            chk("crc frame", POWER_EVENT_OUT_N, c[0]);
        end
        TX_BUSY <= 1'b1;
        bus(1'b1, wpm_pkg::OFS_PMCSR, 32'h8003);
        bus(1'b1, wpm_pkg::OFS_PMCSR, 32'h0);
        #1 seen = TX_RESTART;
        repeat (2) begin
            @(posedge CLK);
            #1 seen = seen | TX_RESTART;
        end
        chk("tx restart", seen, 1);
        TX_BUSY <= 1'b0;
        bus(1'b1, wpm_pkg::OFS_PMCSR, 32'h3);
        RST_N <= 1'b0;
        @(posedge CLK);
        RST_N <= 1'b1;
        #1 chk("reset halt", RX_HALT, 0);
        repeat (2) @(posedge CLK);
        bus(1'b0, wpm_pkg::OFS_PMCSR, 32'h0);
        chk("reset state", rd[1:0], 2'b00);
        give_verdict();
    end
endmodule // wake_power_management_tb
